/* File: logic/crx_irq_enable.sv */
// Receiver flag and interrupt enable registers with request gating.
// Assumes init request and acknowledge, error counters and event strobes come
// from logic on CLOCK; only the CAN receive pin is asynchronous.
//
// Functional notes
// - While init is both requested and acknowledged the enable bits 7, 6, 1 and 0 are held at reset.
// - The enable register reads at any time and takes writes only while neither init request nor acknowledge is set.
// - Both sensitivity fields keep their value when init mode is entered.
// - A set wake-up flag with bit 7 enabled drives the wake-up request.
// - A set status change flag drives the error request only with bit 6 enabled.
// - Receiver sensitivity 00 none, 01 bus-off in or out, 10 passive or bus-off in or out.
// - Transmitter sensitivity in bits 3:2 uses the same codes, and 11 takes every change.
// - State indications follow the real states but only update while no change is pending.
// - A set overrun flag drives the error request only with bit 1 enabled.
// - A set receive full flag drives the receive request only with bit 0 enabled.
// - Receiver state is 00 up to 96, 01 up to 127, 10 above, 11 when transmit count passes 255.
// - Bus activity in sleep with wake detection enabled sets the wake-up flag.
// - A message moved into the foreground sets receive full; no shift until it is cleared.
// - When the transmitter leaves bus-off the receiver indication returns to no error.
`timescale 1ns/1ps
`default_nettype none
`include "crx_regs.svh"

module crx_irq_enable (
	input  wire logic                CLOCK,
	input  wire logic                RESET,
	input  wire logic [7:0]          ADDR,
	input  wire logic [7:0]          WDATA,
	input  wire logic                WR,
	input  wire logic                RD,
	output var  logic [7:0]          RDATA,
	input  wire logic                INIT_REQUEST,
	input  wire logic                INIT_ACKNOWLEDGE,
	input  wire logic                SLEEP_ACTIVE,
	input  wire logic                WAKEUP_DETECT_ENABLE,
	input  wire logic                CAN_RX_PIN,
	input  wire crx_pkg::crx_count_t RX_ERROR_COUNT,
	input  wire crx_pkg::crx_count_t TX_ERROR_COUNT,
	input  wire logic                OVERRUN_EVENT,
	input  wire logic                FIFO_NOT_EMPTY,
	output var  logic                RX_SHIFT,
	output var  logic                WAKEUP_IRQ,
	output var  logic                ERROR_IRQ,
	output var  logic                RX_IRQ
);

	// Level of the transmitter from its error count.
	function automatic crx_pkg::crx_state_t tx_level(input crx_pkg::crx_count_t tec);
		crx_pkg::crx_state_t lv;
		lv = `CRX_ST_OK;
		if (tec > `CRX_LIM_BOFF)
			lv = `CRX_ST_BOFF;
		else if (tec > `CRX_LIM_PASSIVE)
			lv = `CRX_ST_PASSIVE;
		else if (tec > `CRX_LIM_WARN)
			lv = `CRX_ST_WARN;
		return lv;
	endfunction : tx_level

	// Level of the receiver; bus-off is borrowed from the transmit count.
	function automatic crx_pkg::crx_state_t rx_level(input crx_pkg::crx_count_t rec,
		input crx_pkg::crx_count_t tec);
		crx_pkg::crx_state_t lv;
		lv = `CRX_ST_OK;
		if (tec > `CRX_LIM_BOFF)
			lv = `CRX_ST_BOFF;
		else if (rec > `CRX_LIM_PASSIVE)
			lv = `CRX_ST_PASSIVE;
		else if (rec > `CRX_LIM_WARN)
			lv = `CRX_ST_WARN;
		return lv;
	endfunction : rx_level

	// Whether a move between two levels counts at the chosen sensitivity.
	function automatic logic sens_hit(input crx_pkg::crx_sens_t sens,
		input crx_pkg::crx_state_t old_st, input crx_pkg::crx_state_t new_st);
		logic hit;
		hit = 1'b0;
		case (sens)
			`CRX_SENS_NONE:    hit = 1'b0;
			`CRX_SENS_BOFF:    hit = (old_st == `CRX_ST_BOFF) != (new_st == `CRX_ST_BOFF);
			`CRX_SENS_PASSIVE: hit = old_st[1] != new_st[1];
			`CRX_SENS_ALL:     hit = old_st != new_st;
			default:           hit = 1'b0;
		endcase
		return hit;
	endfunction : sens_hit

	logic                in_init;
	logic                wr_allowed;
	logic                wr_rier;
	logic                wr_rflg;
	logic                bus_idle_sync;
	logic                bus_active;

	logic                wake_ie_reg;
	logic                csc_ie_reg;
	crx_pkg::crx_sens_t  rx_sens_reg;
	crx_pkg::crx_sens_t  tx_sens_reg;
	logic                ovr_ie_reg;
	logic                rxf_ie_reg;

	logic                wake_flag_reg;
	logic                csc_flag_reg;
	logic                ovr_flag_reg;
	logic                rxf_flag_reg;
	crx_pkg::crx_state_t rx_stat_reg;
	crx_pkg::crx_state_t tx_stat_reg;
	logic                tx_boff_reg;

	crx_pkg::crx_state_t tx_now;
	crx_pkg::crx_state_t rx_now;
	logic                tx_leave_boff;
	logic                csc_hit;
	logic                shift_now;
	crx_pkg::crx_byte_t  rier_view;
	crx_pkg::crx_byte_t  rflg_view;
	crx_pkg::crx_byte_t  rdata_next;

	localparam crx_pkg::crx_byte_t RIER_RST = `CRX_RIER_RESET;

	assign in_init    = INIT_REQUEST & INIT_ACKNOWLEDGE;
	assign wr_allowed = ~INIT_REQUEST & ~INIT_ACKNOWLEDGE;
	assign wr_rier    = WR & wr_allowed & (ADDR == `CRX_OFF_RIER);
	assign wr_rflg    = WR & wr_allowed & (ADDR == `CRX_OFF_RFLG);

	// The receive pin is dominant low; any dominant bit counts as activity.
	crx_sync #(
		.RESET_VAL (1'b1)
	) u_rx_sync (
		.clk (CLOCK),
		.rst (RESET),
		.d   (CAN_RX_PIN),
		.q   (bus_idle_sync)
	);

	assign bus_active = ~bus_idle_sync;

	// Enable bits drop back to reset for the whole of init mode.
	always_ff @(posedge CLOCK) begin
		if (RESET || in_init) begin
			wake_ie_reg <= RIER_RST[`CRX_BIT_WAKE];
			csc_ie_reg  <= RIER_RST[`CRX_BIT_CSC];
			ovr_ie_reg  <= RIER_RST[`CRX_BIT_OVR];
			rxf_ie_reg  <= RIER_RST[`CRX_BIT_RXF];
		end else if (wr_rier) begin
			wake_ie_reg <= WDATA[`CRX_BIT_WAKE];
			csc_ie_reg  <= WDATA[`CRX_BIT_CSC];
			ovr_ie_reg  <= WDATA[`CRX_BIT_OVR];
			rxf_ie_reg  <= WDATA[`CRX_BIT_RXF];
		end
	end

	// Sensitivity fields survive init mode; only the reset input clears them.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			rx_sens_reg <= RIER_RST[`CRX_FLD_RX_HI:`CRX_FLD_RX_LO];
			tx_sens_reg <= RIER_RST[`CRX_FLD_TX_HI:`CRX_FLD_TX_LO];
		end else if (wr_rier) begin
			rx_sens_reg <= WDATA[`CRX_FLD_RX_HI:`CRX_FLD_RX_LO];
			tx_sens_reg <= WDATA[`CRX_FLD_TX_HI:`CRX_FLD_TX_LO];
		end
	end

	// Actual levels from the counters.
	always_comb begin
		tx_now        = tx_level(TX_ERROR_COUNT);
		tx_leave_boff = tx_boff_reg & (tx_now != `CRX_ST_BOFF);
		rx_now        = rx_level(RX_ERROR_COUNT, TX_ERROR_COUNT);
		if (tx_leave_boff)
			rx_now = `CRX_ST_OK;
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			tx_boff_reg <= 1'b0;
		else
			tx_boff_reg <= tx_now == `CRX_ST_BOFF;
	end

	// A change counts only when no earlier change is still pending.
	always_comb begin
		csc_hit = ~csc_flag_reg & (
			sens_hit(rx_sens_reg, rx_stat_reg, rx_now) |
			sens_hit(tx_sens_reg, tx_stat_reg, tx_now));
	end

	// Indications freeze while the change flag is set, then catch up.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			rx_stat_reg <= `CRX_ST_OK;
			tx_stat_reg <= `CRX_ST_OK;
		end else if (!csc_flag_reg) begin
			rx_stat_reg <= rx_now;
			tx_stat_reg <= tx_now;
		end
	end

	// Flags are written one to clear; a set in the same cycle wins.
	always_ff @(posedge CLOCK) begin
		if (RESET)
			csc_flag_reg <= 1'b0;
		else if (csc_hit)
			csc_flag_reg <= 1'b1;
		else if (wr_rflg && WDATA[`CRX_BIT_CSC])
			csc_flag_reg <= 1'b0;
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			wake_flag_reg <= 1'b0;
		else if (SLEEP_ACTIVE && WAKEUP_DETECT_ENABLE && bus_active)
			wake_flag_reg <= 1'b1;
		else if (wr_rflg && WDATA[`CRX_BIT_WAKE])
			wake_flag_reg <= 1'b0;
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			ovr_flag_reg <= 1'b0;
		else if (OVERRUN_EVENT)
			ovr_flag_reg <= 1'b1;
		else if (wr_rflg && WDATA[`CRX_BIT_OVR])
			ovr_flag_reg <= 1'b0;
	end

	// The foreground buffer is refilled only while the full flag is clear.
	assign shift_now = FIFO_NOT_EMPTY & ~rxf_flag_reg;

	always_ff @(posedge CLOCK) begin
		if (RESET)
			rxf_flag_reg <= 1'b0;
		else if (shift_now)
			rxf_flag_reg <= 1'b1;
		else if (wr_rflg && WDATA[`CRX_BIT_RXF])
			rxf_flag_reg <= 1'b0;
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			RX_SHIFT <= 1'b0;
		else
			RX_SHIFT <= shift_now;
	end

	// Interrupt requests are registered from flag and enable.
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			WAKEUP_IRQ <= 1'b0;
			ERROR_IRQ  <= 1'b0;
			RX_IRQ     <= 1'b0;
		end else begin
			WAKEUP_IRQ <= wake_flag_reg & wake_ie_reg;
			ERROR_IRQ  <= (csc_flag_reg & csc_ie_reg) |
				(ovr_flag_reg & ovr_ie_reg);
			RX_IRQ     <= rxf_flag_reg & rxf_ie_reg;
		end
	end

	// Register views and the read port.
	always_comb begin
		rier_view = {wake_ie_reg, csc_ie_reg, rx_sens_reg, tx_sens_reg,
			ovr_ie_reg, rxf_ie_reg};
		rflg_view = {wake_flag_reg, csc_flag_reg, rx_stat_reg, tx_stat_reg,
			ovr_flag_reg, rxf_flag_reg};
		rdata_next = 8'h00;
		if (RD) begin
			case (ADDR)
				`CRX_OFF_RIER: rdata_next = rier_view;
				`CRX_OFF_RFLG: rdata_next = rflg_view;
				default:       rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			RDATA <= 8'h00;
		else
			RDATA <= rdata_next;
	end

endmodule : crx_irq_enable

`default_nettype wire

/* File: common/crx_regs.svh */
// Register offsets, field positions, reset values and error-level thresholds
// for the receiver interrupt enable block.
// Assumes byte-wide registers on a plain strobe port with 8-bit addresses.
`ifndef CRX_REGS_SVH
`define CRX_REGS_SVH

`define CRX_OFF_RFLG       8'h04
`define CRX_OFF_RIER       8'h05

`define CRX_RIER_RESET     8'h00
`define CRX_RFLG_RESET     8'h00

`define CRX_BIT_WAKE       7
`define CRX_BIT_CSC        6
`define CRX_FLD_RX_HI      5
`define CRX_FLD_RX_LO      4
`define CRX_FLD_TX_HI      3
`define CRX_FLD_TX_LO      2
`define CRX_BIT_OVR        1
`define CRX_BIT_RXF        0

`define CRX_SENS_NONE      2'h0
`define CRX_SENS_BOFF      2'h1
`define CRX_SENS_PASSIVE   2'h2
`define CRX_SENS_ALL       2'h3

`define CRX_ST_OK          2'h0
`define CRX_ST_WARN        2'h1
`define CRX_ST_PASSIVE     2'h2
`define CRX_ST_BOFF        2'h3

`define CRX_LIM_WARN       9'h060
`define CRX_LIM_PASSIVE    9'h07f
`define CRX_LIM_BOFF       9'h0ff

`endif

/* File: common/crx_pkg.sv */
// Types shared by the receiver interrupt enable block.
// Assumes the constants header is included where offsets are needed.
package crx_pkg;

	typedef logic [1:0] crx_state_t;
	typedef logic [1:0] crx_sens_t;
	typedef logic [7:0] crx_byte_t;
	typedef logic [8:0] crx_count_t;

endpackage : crx_pkg

/* File: logic/crx_sync.sv */
// Two-flop synchroniser for a single level from outside the clock domain.
// Assumes the input may change at any time relative to CLOCK.
`timescale 1ns/1ps
`default_nettype none

module crx_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	output var  logic q
);

	logic meta_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			q        <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule : crx_sync

`default_nettype wire

/* File: sim/crx_irq_checker.sv */
// Port assertions for the receiver interrupt enable block.
// Assumes it is bound to crx_irq_enable and shares its single clock.
`timescale 1ns/1ps
`default_nettype none

module crx_irq_checker (
	input wire logic       CLOCK,
	input wire logic       RESET,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       INIT_REQUEST,
	input wire logic       INIT_ACKNOWLEDGE,
	input wire logic       FIFO_NOT_EMPTY,
	input wire logic       RX_SHIFT,
	input wire logic       WAKEUP_IRQ,
	input wire logic       ERROR_IRQ,
	input wire logic       RX_IRQ
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);
	logic in_init;
	logic wr_ok;
	assign in_init = INIT_REQUEST && INIT_ACKNOWLEDGE;
	assign wr_ok = WR && !INIT_REQUEST && !INIT_ACKNOWLEDGE && ADDR == 8'h05;

	read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("Read data not idle.");
	init_irq_a: assert property (in_init [*2] |=> !WAKEUP_IRQ && !ERROR_IRQ && !RX_IRQ)
		else $error("Request during init.");
	init_mask_a: assert property (in_init [*2] ##0 RD && ADDR == 8'h05
		|=> RDATA[7:6] == 2'h0 && RDATA[1:0] == 2'h0)
		else $error("Enable bits not held in init.");
	wake_mask_a: assert property (wr_ok && !WDATA[7] |=> ##1 !WAKEUP_IRQ)
		else $error("Wake request not masked.");
	err_mask_a: assert property (wr_ok && !WDATA[6] && !WDATA[1] |=> ##1 !ERROR_IRQ)
		else $error("Error request not masked.");
	rx_mask_a: assert property (wr_ok && !WDATA[0] |=> ##1 !RX_IRQ)
		else $error("Receive request not masked.");
	shift_once_a: assert property (RX_SHIFT |=> !RX_SHIFT)
		else $error("Shift repeated.");
	shift_cause_a: assert property (RX_SHIFT |-> $past(FIFO_NOT_EMPTY))
		else $error("Shift without entry.");

	cover property (RX_SHIFT);
	cover property (in_init [*2] ##0 RD);
	cover property ($rose(ERROR_IRQ));
endmodule : crx_irq_checker

bind crx_irq_enable crx_irq_checker crx_irq_checker_inst (.CLOCK, .RESET, .ADDR, .WDATA,
	.WR, .RD, .RDATA, .INIT_REQUEST, .INIT_ACKNOWLEDGE, .FIFO_NOT_EMPTY, .RX_SHIFT,
	.WAKEUP_IRQ, .ERROR_IRQ, .RX_IRQ);
`default_nettype wire

/* File: sim/crx_host.sv */
// Host bus master model for the register port.
// Assumes reads return data in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none

module crx_host (
	input  wire logic       CLOCK,
	input  wire logic [7:0] RDATA,
	output var  logic [7:0] ADDR,
	output var  logic [7:0] WDATA,
	output var  logic       WR,
	output var  logic       RD
);
	// The host never touches receive buffers, so none are read with the full flag clear.
	initial begin
		ADDR = 8'h00;
		WDATA = 8'h00;
		WR = 1'b0;
		RD = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
		WDATA <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1;
		d = RDATA;
	endtask : rd
endmodule : crx_host
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the receiver interrupt enable block.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic CLOCK = 1'b0;
	logic RESET = 1'b1;
	logic [7:0] ADDR, WDATA, RDATA;
	logic WR, RD, RX_SHIFT, WAKEUP_IRQ, ERROR_IRQ, RX_IRQ;
	logic INIT_REQUEST = 1'b0, INIT_ACKNOWLEDGE = 1'b0, SLEEP_ACTIVE = 1'b0;
	logic WAKEUP_DETECT_ENABLE = 1'b0, CAN_RX_PIN = 1'b1;
	logic OVERRUN_EVENT = 1'b0, FIFO_NOT_EMPTY = 1'b0;
	crx_pkg::crx_count_t RX_ERROR_COUNT = 9'h000, TX_ERROR_COUNT = 9'h000;
	int err_total = 0;
	int checked = 0;
	always #12.5 CLOCK = ~CLOCK;

	crx_host crx_host_inst (.CLOCK, .RDATA, .ADDR, .WDATA, .WR, .RD);
	crx_irq_enable crx_irq_enable_inst (.CLOCK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.INIT_REQUEST, .INIT_ACKNOWLEDGE, .SLEEP_ACTIVE, .WAKEUP_DETECT_ENABLE, .CAN_RX_PIN,
		.RX_ERROR_COUNT, .TX_ERROR_COUNT, .OVERRUN_EVENT, .FIFO_NOT_EMPTY, .RX_SHIFT,
		.WAKEUP_IRQ, .ERROR_IRQ, .RX_IRQ);

	task automatic summarize();
		$display("mismatches %0d of %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask : cyc
	task automatic s_reg();
		logic [7:0] d;
		crx_host_inst.rd(8'h05, d);
		chk(d, 8'h00);
		crx_host_inst.wr(8'h05, 8'hff);
		crx_host_inst.rd(8'h05, d);
		chk(d, 8'hff);
		crx_host_inst.rd(8'h10, d);
		chk(d, 8'h00);
	endtask : s_reg
	task automatic s_init();
		logic [7:0] d;
		@(posedge CLOCK);
		INIT_REQUEST <= 1'b1;
		crx_host_inst.wr(8'h05, 8'h00);
		crx_host_inst.rd(8'h05, d);
		chk(d, 8'hff);
		@(posedge CLOCK);
		INIT_ACKNOWLEDGE <= 1'b1;
		cyc(2);
		crx_host_inst.rd(8'h05, d);
		chk(d, 8'h3c);
		crx_host_inst.wr(8'h05, 8'h00);
		crx_host_inst.rd(8'h05, d);
		chk(d, 8'h3c);
		@(posedge CLOCK);
		INIT_REQUEST <= 1'b0;
		INIT_ACKNOWLEDGE <= 1'b0;
		crx_host_inst.wr(8'h05, 8'h00);
		crx_host_inst.rd(8'h05, d);
		chk(d, 8'h00);
	endtask : s_init
	task automatic s_state();
		logic [7:0] d;
		logic [8:0] lv;
		logic e;
		for (int s = 0; s < 2; s++)
			for (int c = 0; c < 4; c++)
				for (int l = 1; l < 4; l++) begin
					e = c == 3 || (c == 2 && l > 1) || (c == 1 && l == 3);
					lv = l == 1 ? 9'h061 : 9'h080;
					crx_host_inst.wr(8'h05, 8'(8'h40 | (s ? c << 4 : c << 2)));
					@(posedge CLOCK);
					TX_ERROR_COUNT <= l == 3 ? 9'h100 : (s ? 9'h000 : lv);
					RX_ERROR_COUNT <= s && l < 3 ? lv : 9'h000;
					cyc(4);
					chk({7'h00, ERROR_IRQ}, {7'h00, e});
					crx_host_inst.rd(8'h04, d);
					chk({7'h00, d[6]}, {7'h00, e});
					chk(s ? d[5:4] : d[3:2], 8'(l));
					@(posedge CLOCK);
					TX_ERROR_COUNT <= 9'h000;
					RX_ERROR_COUNT <= 9'h000;
					cyc(4);
					crx_host_inst.rd(8'h04, d);
					chk(s ? d[5:4] : d[3:2], e ? 8'(l) : 8'h00);
					crx_host_inst.wr(8'h04, 8'h40);
					cyc(2);
					crx_host_inst.wr(8'h04, 8'h40);
					cyc(2);
					crx_host_inst.rd(8'h04, d);
					chk(d, 8'h00);
				end
	endtask : s_state
	task automatic s_boff();
		logic [7:0] d;
		// Receiver passive while the transmitter is bus-off, then the transmitter recovers.
		crx_host_inst.wr(8'h05, 8'h30);
		@(posedge CLOCK);
		RX_ERROR_COUNT <= 9'h080;
		TX_ERROR_COUNT <= 9'h100;
		cyc(3);
		crx_host_inst.wr(8'h04, 8'h40);
		cyc(2);
		@(posedge CLOCK);
		TX_ERROR_COUNT <= 9'h000;
		cyc(3);
		crx_host_inst.rd(8'h04, d);
		chk(d, 8'h40);
		chk({7'h00, ERROR_IRQ}, 8'h00);
		@(posedge CLOCK);
		RX_ERROR_COUNT <= 9'h000;
		cyc(2);
		crx_host_inst.wr(8'h04, 8'h40);
		cyc(2);
		crx_host_inst.rd(8'h04, d);
		chk(d, 8'h00);
	endtask : s_boff
	task automatic s_ovr();
		logic [7:0] d;
		crx_host_inst.wr(8'h05, 8'h02);
		@(posedge CLOCK);
		OVERRUN_EVENT <= 1'b1;
		@(posedge CLOCK);
		OVERRUN_EVENT <= 1'b0;
		cyc(3);
		chk({7'h00, ERROR_IRQ}, 8'h01);
		crx_host_inst.wr(8'h05, 8'h00);
		cyc(2);
		chk({7'h00, ERROR_IRQ}, 8'h00);
		crx_host_inst.wr(8'h04, 8'h02);
		crx_host_inst.rd(8'h04, d);
		chk(d, 8'h00);
	endtask : s_ovr
	task automatic s_rx();
		int n;
		crx_host_inst.wr(8'h05, 8'h01);
		@(posedge CLOCK);
		FIFO_NOT_EMPTY <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			n = 0;
			for (int i = 0; i < 8; i++) begin
				cyc(1);
				n += RX_SHIFT;
			end
			chk(8'(n), 8'h01);
			chk({7'h00, RX_IRQ}, 8'h01);
			crx_host_inst.wr(8'h04, 8'h01);
		end
		@(posedge CLOCK);
		FIFO_NOT_EMPTY <= 1'b0;
		crx_host_inst.wr(8'h05, 8'h00);
		cyc(2);
		chk({7'h00, RX_IRQ}, 8'h00);
	endtask : s_rx
	task automatic s_wake();
		// Software sets bit 7 before sleeping; wake detection is enabled in the same cycle as sleep.
		crx_host_inst.wr(8'h05, 8'h80);
		@(posedge CLOCK);
		SLEEP_ACTIVE <= 1'b1;
		WAKEUP_DETECT_ENABLE <= 1'b1;
		CAN_RX_PIN <= 1'b0;
		for (int i = 0; i < 8 && WAKEUP_IRQ !== 1'b1; i++)
			cyc(1);
		chk({7'h00, WAKEUP_IRQ}, 8'h01);
		if (WAKEUP_IRQ !== 1'b1)
			summarize();
		@(posedge CLOCK);
		CAN_RX_PIN <= 1'b1;
		SLEEP_ACTIVE <= 1'b0;
		crx_host_inst.wr(8'h05, 8'h00);
		cyc(2);
		chk({7'h00, WAKEUP_IRQ}, 8'h00);
	endtask : s_wake

	initial begin
		repeat (3) @(posedge CLOCK);
		RESET <= 1'b0;
		s_reg();
		s_init();
		s_state();
		s_boff();
		s_ovr();
		s_rx();
		s_wake();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
